// ===== pkg/operand_addr_pkg.sv
package operand_addr_pkg;

    // register window pointers after reset: slices c0..c7 and c8..cf
    localparam logic [7:0] WIN_PTR_A_RST = 8'hC0;
    localparam logic [7:0] WIN_PTR_B_RST = 8'hC8;
    // low stack byte after reset, so the first push lands one below it
    localparam logic [7:0] STACK_LOW_RST = 8'hFF;
    localparam logic [7:0] STACK_STEP = 8'h01;

    // an 8-bit register operand with this upper nibble is a working register
    localparam logic [3:0] WORK_PREFIX = 4'hC;
    // start of the upper control area that indirect and indexed forms cannot reach
    localparam logic [7:0] CTRL_AREA_LO = 8'hC0;

    // field layout of a working register address and a window pointer
    localparam int WORK_SEL_BIT = 3;
    localparam int SLICE_MSB = 7;
    localparam int SLICE_LSB = 3;
    localparam int INSLICE_MSB = 2;

    // register pairs: high byte at even address, low byte at the odd one
    localparam logic [7:0] PAIR_EVEN_MASK = 8'hFE;
    localparam logic [7:0] PAIR_ODD_BIT = 8'h01;

    // vector calls stay in the lowest page of program memory
    localparam logic [7:0] VECTOR_PAGE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONES_BYTE = 8'hFF;

    // the seven explicit operand addressing modes
    typedef enum logic [2:0] {
        MODE_REGISTER,
        MODE_POINTER_IN_REG,
        MODE_INDEXED,
        MODE_ABSOLUTE_OPERAND,
        MODE_VECTOR_TABLE_CALL,
        MODE_PC_OFFSET_JUMP,
        MODE_LITERAL_OPERAND
    } addr_mode_t;

    // instruction classes that matter to operand addressing
    typedef enum logic [3:0] {
        OP_LOAD_REGISTER,
        OP_LOAD_PROGRAM_MEMORY,
        OP_LOAD_EXTERNAL_MEMORY,
        OP_JUMP_ABSOLUTE,
        OP_CALL,
        OP_BIT_TEST_JUMP_IF_FALSE,
        OP_BIT_TEST_JUMP_IF_TRUE,
        OP_DECREMENT_JUMP_NONZERO,
        OP_COMPARE_INCR_JUMP_EQUAL,
        OP_COMPARE_INCR_JUMP_UNEQUAL,
        OP_JUMP_RELATIVE,
        OP_ALU
    } instr_class_t;

    // where the resolved address points
    typedef enum logic [2:0] {
        SPACE_REGFILE,
        SPACE_PROGRAM,
        SPACE_EXTERNAL,
        SPACE_PC_TARGET,
        SPACE_LITERAL
    } addr_space_t;

endpackage

// ===== rtl/work_window_regs.sv
`timescale 1ns/1ps
// holds the two working register window pointers
module work_window_regs
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ptrWrEn,
    input wire logic ptrWrSel,
    input wire logic [7:0] ptrWrData,
    output logic [7:0] workWindowPtrA,
    output logic [7:0] workWindowPtrB
);

    logic [7:0] ptrA_r;
    logic [7:0] ptrB_r;

    // software-style writes select one pointer, reset picks the common area
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ptrA_r <= operand_addr_pkg::WIN_PTR_A_RST;
            ptrB_r <= operand_addr_pkg::WIN_PTR_B_RST;
        end
        else if (ptrWrEn)
        begin
            if (ptrWrSel)
                ptrB_r <= ptrWrData;
            else
                ptrA_r <= ptrWrData;
        end
    end

    assign workWindowPtrA = ptrA_r;
    assign workWindowPtrB = ptrB_r;

endmodule // work_window_regs

// ===== rtl/stack_pointer_unit.sv
`timescale 1ns/1ps
// low stack pointer byte with pre-decrement push and post-increment pop
module stack_pointer_unit
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic spWrEn,
    input wire logic [7:0] spWrData,
    input wire logic pushReq,
    input wire logic popReq,
    output logic [7:0] stackPtrLow,
    output logic [7:0] stackAddr,
    output logic stackAddrValid
);

    logic [7:0] sp_r;
    logic [7:0] stackAddr_r;
    logic stackAddrValid_r;
    logic pushOnly;
    logic popOnly;

    // a push and a pop in one cycle are both refused
    assign pushOnly = pushReq && !popReq && !spWrEn;
    assign popOnly = popReq && !pushReq && !spWrEn;

    // pointer update: direct load wins, push moves down first, pop moves up after
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sp_r <= operand_addr_pkg::STACK_LOW_RST;
        else if (spWrEn)
            sp_r <= spWrData;
        else if (pushOnly)
            sp_r <= sp_r - operand_addr_pkg::STACK_STEP;
        else if (popOnly)
            sp_r <= sp_r + operand_addr_pkg::STACK_STEP;
    end

    // access address: push uses the decremented value, pop the current one
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stackAddr_r <= operand_addr_pkg::ZERO_BYTE;
            stackAddrValid_r <= 1'b0;
        end
        else
        begin
            stackAddrValid_r <= pushOnly || popOnly;
            if (pushOnly)
                stackAddr_r <= sp_r - operand_addr_pkg::STACK_STEP;
            else if (popOnly)
                stackAddr_r <= sp_r;
        end
    end

    assign stackPtrLow = sp_r;
    assign stackAddr = stackAddr_r;
    assign stackAddrValid = stackAddrValid_r;

endmodule // stack_pointer_unit

// ===== rtl/operand_address_generation.sv
`timescale 1ns/1ps
module operand_address_generation
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reqValid,
    output logic reqReady,
    input wire operand_addr_pkg::instr_class_t instrClass,
    input wire operand_addr_pkg::addr_mode_t addrMode,
    input wire logic wordOp,
    input wire logic workForm,
    input wire logic [7:0] regField,
    input wire logic [15:0] literalField,
    input wire logic shortOffset,
    input wire logic [15:0] pcNext,
    output logic rfRdEn,
    output logic [7:0] rfRdAddr,
    input wire logic [7:0] rfRdData,
    input wire logic ptrWrEn,
    input wire logic ptrWrSel,
    input wire logic [7:0] ptrWrData,
    output logic [7:0] workWindowPtrA,
    output logic [7:0] workWindowPtrB,
    input wire logic spWrEn,
    input wire logic [7:0] spWrData,
    input wire logic pushReq,
    input wire logic popReq,
    output logic [7:0] stackPtrLow,
    output logic [7:0] stackAddr,
    output logic stackAddrValid,
    output logic resultValid,
    output operand_addr_pkg::addr_space_t resultSpace,
    output logic [15:0] resultAddr,
    output logic [15:0] resultOperand,
    output logic resultSet2,
    output logic modeFault
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ_FIRST,
        ST_READ_SECOND,
        ST_FINISH
    } gen_state_t;

    gen_state_t state_r;
    operand_addr_pkg::instr_class_t instr_r;
    operand_addr_pkg::addr_mode_t mode_r;
    logic word_r;
    logic short_r;
    logic pair_r;
    logic [15:0] lit_r;
    logic [15:0] pc_r;
    logic [7:0] regAddr_r;
    logic [7:0] rdAddr_r;
    logic [7:0] hiByte_r;
    logic [7:0] loByte_r;
    logic resultValid_r;
    operand_addr_pkg::addr_space_t resultSpace_r;
    logic [15:0] resultAddr_r;
    logic [15:0] resultOperand_r;
    logic resultSet2_r;
    logic modeFault_r;

    logic accept;
    logic allowed;
    logic [7:0] regAddrNow;
    logic needRead;
    logic needPair;
    logic [7:0] firstRdAddr;
    operand_addr_pkg::addr_space_t spaceNxt;
    logic [15:0] addrNxt;
    logic [15:0] operandNxt;
    logic set2Nxt;
    logic [15:0] pairWord;
    logic [15:0] offsetExt;

    // the two window pointers
    work_window_regs u_window
    (
        .clk(clk),
        .arst_n(arst_n),
        .ptrWrEn(ptrWrEn),
        .ptrWrSel(ptrWrSel),
        .ptrWrData(ptrWrData),
        .workWindowPtrA(workWindowPtrA),
        .workWindowPtrB(workWindowPtrB)
    );

    // the system stack pointer
    stack_pointer_unit u_stack
    (
        .clk(clk),
        .arst_n(arst_n),
        .spWrEn(spWrEn),
        .spWrData(spWrData),
        .pushReq(pushReq),
        .popReq(popReq),
        .stackPtrLow(stackPtrLow),
        .stackAddr(stackAddr),
        .stackAddrValid(stackAddrValid)
    );

    // joins a window pointer slice with the low three bits of a working address
    function automatic logic [7:0] workAddr(input logic [3:0] nib, input logic [7:0] pa, input logic [7:0] pb);
        logic [7:0] ptr;
        ptr = nib[operand_addr_pkg::WORK_SEL_BIT] ? pb : pa;
        workAddr = {ptr[operand_addr_pkg::SLICE_MSB:operand_addr_pkg::SLICE_LSB],
                    nib[operand_addr_pkg::INSLICE_MSB:0]};
    endfunction

    // true when an address falls in the upper control area
    function automatic logic inCtrlArea(input logic [7:0] a);
        inCtrlArea = (a >= operand_addr_pkg::CTRL_AREA_LO);
    endfunction

    // true for a memory load class
    function automatic logic isMemLoad(input operand_addr_pkg::instr_class_t ic);
        isMemLoad = (ic == operand_addr_pkg::OP_LOAD_PROGRAM_MEMORY) ||
                    (ic == operand_addr_pkg::OP_LOAD_EXTERNAL_MEMORY);
    endfunction

    // true for the classes that branch by a pc displacement
    function automatic logic isRelJump(input operand_addr_pkg::instr_class_t ic);
        isRelJump = (ic == operand_addr_pkg::OP_BIT_TEST_JUMP_IF_FALSE) ||
                    (ic == operand_addr_pkg::OP_BIT_TEST_JUMP_IF_TRUE) ||
                    (ic == operand_addr_pkg::OP_DECREMENT_JUMP_NONZERO) ||
                    (ic == operand_addr_pkg::OP_COMPARE_INCR_JUMP_EQUAL) ||
                    (ic == operand_addr_pkg::OP_COMPARE_INCR_JUMP_UNEQUAL) ||
                    (ic == operand_addr_pkg::OP_JUMP_RELATIVE);
    endfunction

    // true for absolute jump and call, whose addresses go to the pc
    function automatic logic isPcLoad(input operand_addr_pkg::instr_class_t ic);
        isPcLoad = (ic == operand_addr_pkg::OP_JUMP_ABSOLUTE) || (ic == operand_addr_pkg::OP_CALL);
    endfunction

    // target space of pointer and indexed forms for a class
    function automatic operand_addr_pkg::addr_space_t memSpace(input operand_addr_pkg::instr_class_t ic);
        if (ic == operand_addr_pkg::OP_LOAD_PROGRAM_MEMORY)
            memSpace = operand_addr_pkg::SPACE_PROGRAM;
        else if (ic == operand_addr_pkg::OP_LOAD_EXTERNAL_MEMORY)
            memSpace = operand_addr_pkg::SPACE_EXTERNAL;
        else if (isPcLoad(ic))
            memSpace = operand_addr_pkg::SPACE_PC_TARGET;
        else
            memSpace = operand_addr_pkg::SPACE_REGFILE;
    endfunction

    // mode permission table per class
    always_comb
    begin
        allowed = 1'b0;
        case (addrMode)
            operand_addr_pkg::MODE_REGISTER:
                allowed = !isPcLoad(instrClass) && (instrClass != operand_addr_pkg::OP_JUMP_RELATIVE);
            operand_addr_pkg::MODE_POINTER_IN_REG:
                allowed = (instrClass != operand_addr_pkg::OP_JUMP_RELATIVE);
            operand_addr_pkg::MODE_INDEXED:
                allowed = (instrClass == operand_addr_pkg::OP_LOAD_REGISTER) || isMemLoad(instrClass);
            operand_addr_pkg::MODE_ABSOLUTE_OPERAND:
                allowed = isPcLoad(instrClass) || isMemLoad(instrClass);
            operand_addr_pkg::MODE_VECTOR_TABLE_CALL:
                allowed = (instrClass == operand_addr_pkg::OP_CALL);
            operand_addr_pkg::MODE_PC_OFFSET_JUMP:
                allowed = isRelJump(instrClass);
            operand_addr_pkg::MODE_LITERAL_OPERAND:
                allowed = (instrClass == operand_addr_pkg::OP_LOAD_REGISTER) ||
                          (instrClass == operand_addr_pkg::OP_ALU);
            default:
                allowed = 1'b0;
        endcase
    end

    // operand register resolution and read plan for a new request
    always_comb
    begin
        if (workForm || (regField[7:4] == operand_addr_pkg::WORK_PREFIX))
            regAddrNow = workAddr(regField[3:0], workWindowPtrA, workWindowPtrB);
        else
            regAddrNow = regField;
        needRead = (addrMode == operand_addr_pkg::MODE_REGISTER) ||
                   (addrMode == operand_addr_pkg::MODE_POINTER_IN_REG) ||
                   (addrMode == operand_addr_pkg::MODE_INDEXED);
        if (addrMode == operand_addr_pkg::MODE_REGISTER)
            needPair = wordOp;
        else if (addrMode == operand_addr_pkg::MODE_POINTER_IN_REG)
            needPair = (memSpace(instrClass) != operand_addr_pkg::SPACE_REGFILE);
        else if (addrMode == operand_addr_pkg::MODE_INDEXED)
            needPair = isMemLoad(instrClass);
        else
            needPair = 1'b0;
        firstRdAddr = needPair ? (regAddrNow & operand_addr_pkg::PAIR_EVEN_MASK) : regAddrNow;
    end

    assign accept = reqValid && (state_r == ST_IDLE);
    assign reqReady = (state_r == ST_IDLE);
    assign rfRdEn = (state_r == ST_READ_FIRST) || (state_r == ST_READ_SECOND);
    assign rfRdAddr = rdAddr_r;

    // sequencer: optional one or two register reads, then one result cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (accept && allowed)
                        state_r <= needRead ? ST_READ_FIRST : ST_FINISH;
                ST_READ_FIRST:
                    state_r <= pair_r ? ST_READ_SECOND : ST_FINISH;
                ST_READ_SECOND:
                    state_r <= ST_FINISH;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // request capture
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            instr_r <= operand_addr_pkg::OP_ALU;
            mode_r <= operand_addr_pkg::MODE_REGISTER;
            word_r <= 1'b0;
            short_r <= 1'b0;
            pair_r <= 1'b0;
            lit_r <= 16'h0000;
            pc_r <= 16'h0000;
            regAddr_r <= operand_addr_pkg::ZERO_BYTE;
        end
        else if (accept && allowed)
        begin
            instr_r <= instrClass;
            mode_r <= addrMode;
            word_r <= wordOp;
            short_r <= shortOffset;
            pair_r <= needPair;
            lit_r <= literalField;
            pc_r <= pcNext;
            regAddr_r <= regAddrNow;
        end
    end

    // register file read address and captured bytes, high byte from the even one
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdAddr_r <= operand_addr_pkg::ZERO_BYTE;
            hiByte_r <= operand_addr_pkg::ZERO_BYTE;
            loByte_r <= operand_addr_pkg::ZERO_BYTE;
        end
        else if (accept && allowed)
        begin
            rdAddr_r <= firstRdAddr;
            hiByte_r <= operand_addr_pkg::ZERO_BYTE;
        end
        else if (state_r == ST_READ_FIRST)
        begin
            if (pair_r)
            begin
                hiByte_r <= rfRdData;
                rdAddr_r <= rdAddr_r | operand_addr_pkg::PAIR_ODD_BIT;
            end
            else
                loByte_r <= rfRdData;
        end
        else if (state_r == ST_READ_SECOND)
            loByte_r <= rfRdData;
    end

    assign pairWord = {hiByte_r, loByte_r};
    // short memory offsets are signed bytes, long ones a full word
    assign offsetExt = short_r ? {{8{lit_r[7]}}, lit_r[7:0]} : lit_r;

    // effective address and operand per mode
    always_comb
    begin
        spaceNxt = operand_addr_pkg::SPACE_REGFILE;
        addrNxt = 16'h0000;
        operandNxt = 16'h0000;
        set2Nxt = 1'b0;
        case (mode_r)
            operand_addr_pkg::MODE_REGISTER:
            begin
                addrNxt = {operand_addr_pkg::ZERO_BYTE, regAddr_r & (word_r ? operand_addr_pkg::PAIR_EVEN_MASK
                                                                            : operand_addr_pkg::ONES_BYTE)};
                operandNxt = pairWord;
            end
            operand_addr_pkg::MODE_POINTER_IN_REG:
            begin
                spaceNxt = memSpace(instr_r);
                if (pair_r)
                    addrNxt = pairWord;
                else
                begin
                    addrNxt = {operand_addr_pkg::ZERO_BYTE, loByte_r};
                    set2Nxt = inCtrlArea(loByte_r);
                end
            end
            operand_addr_pkg::MODE_INDEXED:
            begin
                spaceNxt = memSpace(instr_r);
                if (pair_r)
                    addrNxt = pairWord + offsetExt;
                else
                begin
                    addrNxt = {operand_addr_pkg::ZERO_BYTE, lit_r[7:0] + loByte_r};
                    set2Nxt = inCtrlArea(lit_r[7:0] + loByte_r);
                end
            end
            operand_addr_pkg::MODE_ABSOLUTE_OPERAND:
            begin
                spaceNxt = memSpace(instr_r);
                addrNxt = lit_r;
            end
            operand_addr_pkg::MODE_VECTOR_TABLE_CALL:
            begin
                spaceNxt = operand_addr_pkg::SPACE_PROGRAM;
                addrNxt = {operand_addr_pkg::VECTOR_PAGE, lit_r[7:0]};
            end
            operand_addr_pkg::MODE_PC_OFFSET_JUMP:
            begin
                spaceNxt = operand_addr_pkg::SPACE_PC_TARGET;
                addrNxt = pc_r + {{8{lit_r[7]}}, lit_r[7:0]};
            end
            operand_addr_pkg::MODE_LITERAL_OPERAND:
            begin
                spaceNxt = operand_addr_pkg::SPACE_LITERAL;
                operandNxt = word_r ? lit_r : {operand_addr_pkg::ZERO_BYTE, lit_r[7:0]};
            end
            default:
                spaceNxt = operand_addr_pkg::SPACE_REGFILE;
        endcase
    end

    // result registers, loaded in the finish cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resultValid_r <= 1'b0;
            resultSpace_r <= operand_addr_pkg::SPACE_REGFILE;
            resultAddr_r <= 16'h0000;
            resultOperand_r <= 16'h0000;
            resultSet2_r <= 1'b0;
        end
        else
        begin
            resultValid_r <= (state_r == ST_FINISH);
            if (state_r == ST_FINISH)
            begin
                resultSpace_r <= spaceNxt;
                resultAddr_r <= addrNxt;
                resultOperand_r <= operandNxt;
                resultSet2_r <= set2Nxt;
            end
        end
    end

    // one-cycle flag for a mode that the class does not permit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            modeFault_r <= 1'b0;
        else
            modeFault_r <= accept && !allowed;
    end

    assign resultValid = resultValid_r;
    assign resultSpace = resultSpace_r;
    assign resultAddr = resultAddr_r;
    assign resultOperand = resultOperand_r;
    assign resultSet2 = resultSet2_r;
    assign modeFault = modeFault_r;

endmodule // operand_address_generation

// ===== verif/operand_address_generation_asserts.sv
`timescale 1ns/1ps
module operand_addr_checker
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire operand_addr_pkg::instr_class_t instrClass,
    input wire operand_addr_pkg::addr_mode_t addrMode,
    input wire logic [7:0] regField,
    input wire logic [15:0] literalField,
    input wire logic [15:0] pcNext,
    input wire logic rfRdEn,
    input wire logic [7:0] rfRdAddr,
    input wire logic [7:0] workWindowPtrA,
    input wire logic [7:0] workWindowPtrB,
    input wire logic spWrEn,
    input wire logic pushReq,
    input wire logic popReq,
    input wire logic [7:0] stackPtrLow,
    input wire logic [7:0] stackAddr,
    input wire logic stackAddrValid,
    input wire logic resultValid,
    input wire operand_addr_pkg::addr_space_t resultSpace,
    input wire logic [15:0] resultAddr,
    input wire logic [15:0] resultOperand,
    input wire logic modeFault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // request taken at this edge, and its vector form
    wire logic take = reqValid && reqReady;
    wire logic vec = take && addrMode == operand_addr_pkg::MODE_VECTOR_TABLE_CALL;
    // stack byte steps down before a push and up after a pop
    property p_push; pushReq && !popReq && !spWrEn |=> stackAddrValid
        && stackAddr == $past(stackPtrLow) - 8'h01; endproperty
    a_push: assert property (p_push) else $error("push address wrong");
    property p_pop; popReq && !pushReq && !spWrEn |=> stackAddr == $past(stackPtrLow)
        && stackPtrLow == stackAddr + 8'h01; endproperty
    a_pop: assert property (p_pop) else $error("pop address wrong");
    // vector form is for calls only and stays in the lowest page
    property p_vfault; vec && instrClass != operand_addr_pkg::OP_CALL |=> modeFault && !resultValid; endproperty
    a_vfault: assert property (p_vfault) else $error("vector form not refused");
    property p_vaddr; vec && instrClass == operand_addr_pkg::OP_CALL |-> ##2 resultValid
        && resultAddr == {8'h00, $past(literalField[7:0], 2)}; endproperty
    a_vaddr: assert property (p_vaddr) else $error("vector address wrong");
    // relative target is next pc plus the sign-extended byte
    property p_rel; take && addrMode == operand_addr_pkg::MODE_PC_OFFSET_JUMP
        && instrClass == operand_addr_pkg::OP_JUMP_RELATIVE |-> ##2 resultValid
        && resultAddr == $past(pcNext, 2) + {{8{$past(literalField[7], 2)}}, $past(literalField[7:0], 2)}; endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    // jump address and literal operand come straight from the instruction
    property p_abs; take && addrMode == operand_addr_pkg::MODE_ABSOLUTE_OPERAND
        && instrClass == operand_addr_pkg::OP_JUMP_ABSOLUTE |-> ##2 resultValid
        && resultAddr == $past(literalField, 2) && resultSpace == operand_addr_pkg::SPACE_PC_TARGET; endproperty
    a_abs: assert property (p_abs) else $error("jump address wrong");
    property p_lit; take && addrMode == operand_addr_pkg::MODE_LITERAL_OPERAND
        && instrClass == operand_addr_pkg::OP_LOAD_REGISTER |-> ##2 resultValid
        && resultOperand[7:0] == $past(literalField[7:0], 2); endproperty
    a_lit: assert property (p_lit) else $error("literal operand wrong");
    // working register: bit 3 picks the pointer, its slice joins the low three bits
    property p_win; take && addrMode == operand_addr_pkg::MODE_REGISTER && instrClass == operand_addr_pkg::OP_ALU
        && regField[7:4] == 4'hC && !regField[0] |=> rfRdEn && rfRdAddr == {($past(regField[3])
        ? $past(workWindowPtrB[7:3]) : $past(workWindowPtrA[7:3])), $past(regField[2:0])}; endproperty
    a_win: assert property (p_win) else $error("working address wrong");
endmodule // operand_addr_checker
bind operand_address_generation operand_addr_checker u_chk (.*);

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 0, arst_n = 0, reqValid = 0, wordOp = 0, workForm = 0, shortOffset = 1, ptrWrEn = 0, ptrWrSel = 0;
    logic spWrEn = 0, pushReq = 0, popReq = 0, reqReady, rfRdEn, stackAddrValid, resultValid, resultSet2, modeFault;
    logic [7:0] regField = 0, ptrWrData = 0, spWrData = 0, rfRdData, rfRdAddr, workWindowPtrA, workWindowPtrB;
    logic [7:0] stackPtrLow, stackAddr;
    logic [15:0] literalField = 0, pcNext = 0, resultAddr, resultOperand, lit = 0;
    logic [35:0] expQ[$], e, g;
    int n_fail = 0, checked = 0, seed = 21006;
    operand_addr_pkg::instr_class_t instrClass = operand_addr_pkg::OP_ALU;
    operand_addr_pkg::addr_mode_t addrMode = operand_addr_pkg::MODE_REGISTER;
    operand_addr_pkg::addr_space_t resultSpace;
    // register file answers with a scrambled copy of the address
    assign rfRdData = rfRdAddr ^ 8'h5A;
    operand_address_generation u_dut (.*);
    initial forever #4 clk = ~clk;
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [35:0] x(input logic [2:0] s, input logic [15:0] a, input logic [15:0] o);
        return {1'b0, s, a, o};
    endfunction
    // note the expectation, then hold the request until it is taken
    task automatic rq(input operand_addr_pkg::instr_class_t c, input operand_addr_pkg::addr_mode_t m,
        input logic [7:0] rf, input logic [35:0] ex);
        expQ.push_back(ex);
        @(negedge clk);
        instrClass = c;
        addrMode = m;
        regField = rf;
        literalField = lit;
        reqValid = 1;
        while (reqReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        reqValid = 0;
    endtask
    // each result or refusal is matched with the oldest note; space 7 marks a refusal, top bit the set-two steering
    always @(negedge clk)
        if (arst_n && (resultValid === 1'b1 || modeFault === 1'b1))
        begin
            e = expQ.pop_front();
            g = modeFault ? 36'h700000000 : {resultSet2, resultSpace, resultAddr, resultOperand};
            check(g, e);
        end
    // cut a hang short far beyond the expected run
    initial
    begin
        #20000;
        n_fail++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        arst_n = 1;
        // four pushes then four pops, back to back
        for (int i = 0; i < 9; i++)
        begin
            @(negedge clk);
            if (i > 0)
                check(36'(stackAddr), 36'(i < 5 ? 8'hFF - 8'(i) : 8'hF6 + 8'(i)));
            pushReq = i < 4;
            popReq = i > 3 && i < 8;
        end
        $display("stack test done");
        // move both windows, then resolve working registers through them
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk);
            ptrWrEn = i < 2;
            ptrWrSel = i[0];
            ptrWrData = i[0] ? 8'hA8 : 8'h70;
        end
        rq(operand_addr_pkg::OP_ALU, operand_addr_pkg::MODE_REGISTER, 8'hC6, x(3'h0, 16'h0076, 16'h002C));
        rq(operand_addr_pkg::OP_ALU, operand_addr_pkg::MODE_REGISTER, 8'hCB, x(3'h0, 16'h00AB, 16'h00F1));
        wordOp = 1;
        rq(operand_addr_pkg::OP_ALU, operand_addr_pkg::MODE_REGISTER, 8'hCA, x(3'h0, 16'h00AA, 16'hF0F1));
        // pointer and indexed forms; register addresses c0h and up are steered to set two
        lit = 16'h00A0;
        rq(operand_addr_pkg::OP_ALU, operand_addr_pkg::MODE_POINTER_IN_REG, 8'h9A, 36'h800C00000);
        rq(operand_addr_pkg::OP_LOAD_REGISTER, operand_addr_pkg::MODE_INDEXED, 8'hC6, 36'h800CC0000);
        rq(operand_addr_pkg::OP_LOAD_EXTERNAL_MEMORY, operand_addr_pkg::MODE_INDEXED, 8'hCA,
            x(operand_addr_pkg::SPACE_EXTERNAL, 16'hF091, 16'h0));
        workForm = 1;
        rq(operand_addr_pkg::OP_LOAD_PROGRAM_MEMORY, operand_addr_pkg::MODE_POINTER_IN_REG, 8'h0A,
            x(operand_addr_pkg::SPACE_PROGRAM, 16'hF0F1, 16'h0));
        $display("window test done");
        // random literals through the modes that need no read, one refusal each pass
        for (int k = 0; k < 6; k++)
        begin
            lit = 16'($random(seed));
            pcNext = 16'($random(seed));
            wordOp = k[0];
            rq(operand_addr_pkg::instr_class_t'(5 + k), operand_addr_pkg::MODE_PC_OFFSET_JUMP, 8'h00,
                x(operand_addr_pkg::SPACE_PC_TARGET, pcNext + {{8{lit[7]}}, lit[7:0]}, 16'h0));
            rq(operand_addr_pkg::OP_JUMP_ABSOLUTE, operand_addr_pkg::MODE_ABSOLUTE_OPERAND, 8'h00,
                x(operand_addr_pkg::SPACE_PC_TARGET, lit, 16'h0));
            rq(operand_addr_pkg::OP_CALL, operand_addr_pkg::MODE_VECTOR_TABLE_CALL, 8'h00,
                x(operand_addr_pkg::SPACE_PROGRAM, {8'h00, lit[7:0]}, 16'h0));
            rq(operand_addr_pkg::OP_LOAD_REGISTER, operand_addr_pkg::MODE_LITERAL_OPERAND, 8'h00,
                x(operand_addr_pkg::SPACE_LITERAL, 16'h0, k[0] ? lit : lit & 16'h00FF));
            rq(operand_addr_pkg::OP_ALU, k[0] ? operand_addr_pkg::MODE_VECTOR_TABLE_CALL
                : operand_addr_pkg::MODE_PC_OFFSET_JUMP, 8'h00, 36'h700000000);
        end
        repeat (10) @(negedge clk);
        check(36'(expQ.size()), 36'h0);
        $display("mode test done");
        stop_test();
    end
endmodule // tb
